// ===== hw/uvrb_defines.vh
// register map, field positions and timing constants of the vendor register bank
`ifndef UVRB_DEFINES_VH
`define UVRB_DEFINES_VH

// immediate addresses
`define UVRB_ADDR_TX_AMP 6'h31
`define UVRB_ADDR_HS_KEY 6'h33
`define UVRB_ADDR_IDC_WR 6'h36
`define UVRB_ADDR_IDC_SET 6'h37
`define UVRB_ADDR_IDC_CLR 6'h38
`define UVRB_ADDR_IO_WR 6'h39
`define UVRB_ADDR_IO_SET 6'h3A
`define UVRB_ADDR_IO_CLR 6'h3B
`define UVRB_ADDR_VENDOR_HI 2'h3
`define UVRB_ADDR_NONE 6'h00
`define UVRB_EXT_PAGE 2'h0

// extended address form: immediate field value that flags an extended access
`define UVRB_EXT_ESCAPE 6'h2F

// writable bit masks, reserved bits are zero except conversion bit 5, which the register clears itself
`define UVRB_MASK_TX_AMP 8'h60
`define UVRB_MASK_HS_KEY 8'h0F
`define UVRB_MASK_IDC 8'h70
`define UVRB_MASK_IO 8'hFE

// reset values
`define UVRB_RST_TX_AMP 8'h00
`define UVRB_RST_HS_KEY 8'h00
`define UVRB_RST_IDC 8'h00
`define UVRB_RST_IO 8'h04

// field positions
`define UVRB_TX_AMP_LSB 5
`define UVRB_TX_AMP_MSB 6
`define UVRB_HS_KEY_MSB 3
`define UVRB_HS_KEY_ON 4'hA
`define UVRB_IDC_DONE 3
`define UVRB_IDC_TRIG 4
`define UVRB_IDC_RSVD 5
`define UVRB_IDC_IRQEN 6
`define UVRB_IO_SWAP 1
`define UVRB_IO_SER_LSB 2
`define UVRB_IO_SER_MSB 3
`define UVRB_IO_PU_PLUS 4
`define UVRB_IO_PU_MINUS 5
`define UVRB_IO_USB_LSB 6
`define UVRB_IO_USB_MSB 7

// id resistance codes
`define UVRB_RID_FLOAT 3'h5
`define UVRB_RID_ERROR 3'h7

// conversion time
`define UVRB_CONV_TIME_NS 282000
`define UVRB_CLK_PERIOD_NS 10

`endif

// ===== hw/uvrb_register_bank.v
// vendor register bank of the ulpi transceiver: amplitude, headset key, id conversion, io and regulator control
`timescale 1ns/1ps
`include "uvrb_defines.vh"

// Notes on behaviour
// - immediate registers are reachable by immediate or extended address alike.
// - vendor registers live at 30h..3Fh, served by immediate reads and writes.
// - amplitude field 6:5 picks nominal, reserved, +7.4 percent or +3.7 percent.
// - headset audio mode is on only while the key field equals 1010.
// - result code maps 0,75,100K,200K,440K ohms, floating 101, error 111.
// - conversion sets the complete flag after 282 microseconds.
// - reading the conversion register clears the flag; carkit status reads do not.
// - writing or setting the trigger starts a conversion; it self-clears when done.
// - with the enable set, a flag rise raises the alternate interrupt unless a synced carkit status read falls in the same cycle.
// - effective enable is vendor enable OR carkit enable.
// - conversion register reads at 36h-38h; write, set, clear at 36h, 37h, 38h.
// - io register reads at 39h-3Bh; write, set, clear at 39h, 3Ah, 3Bh.
// - the swap bit exchanges the two data pins in usb and uart modes.
// - uart regulator level defaults 01, applied on uart entry with transmit enable.
// - bits 4 and 5 add plus and minus 125K pull-ups; forced on in uart mode.
// - usb regulator level defaults 00, used in synchronous, serial and low-power modes.
module uvrb_register_bank #(
    parameter CONV_CYCLES = `UVRB_CONV_TIME_NS / `UVRB_CLK_PERIOD_NS,
    parameter CNT_W = 15
) (
    input wire ref_clk,
    input wire rst,
    input wire reg_wr_stb,
    input wire reg_rd_stb,
    input wire reg_ext,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire carkit_irq_enable,
    input wire carkit_status_rd,
    input wire uart_mode,
    input wire serial_transmit_enable,
    input wire [2:0] id_adc_code,
    output reg [7:0] reg_rdata,
    output reg reg_rd_valid,
    output reg [1:0] tx_amplitude,
    output reg headset_mode_on,
    output reg id_conv_run,
    output reg [2:0] id_resistance_code,
    output reg id_conv_complete,
    output reg alt_irq,
    output reg data_line_exchange,
    output reg [1:0] ldo_level,
    output reg charger_pullup_plus,
    output reg charger_pullup_minus
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    reg [7:0] amp_reg;
    reg [7:0] key_reg;
    reg [6:4] idc_ctrl;
    reg [7:1] io_reg;
    reg [CNT_W-1:0] conv_cnt;
    reg [2:0] adc_meta;
    reg [2:0] adc_sync;
    reg uart_meta;
    reg uart_sync;
    reg txd_meta;
    reg txd_sync;
    reg ck_en_meta;
    reg ck_en_sync;
    reg ck_rd_meta;
    reg ck_rd_sync;
    reg [7:0] next_rdata;
    reg [7:0] next_idc;
    reg [7:0] next_io;
    wire [5:0] eff_addr;
    wire addr_ok;
    wire idc_hit;
    wire io_hit;
    wire [7:0] io_rst_val;
    wire irq_en;
    wire [7:0] idc_view;
    wire [7:0] io_view;
    wire conv_done;

    // extended alias
    // both access forms collapse onto the same 6-bit immediate space
    // an extended address past 3Fh is steered to a dead address so it never folds back
    assign addr_ok = !reg_ext || (reg_addr[7:6] == `UVRB_EXT_PAGE);
    assign eff_addr = addr_ok ? reg_addr[5:0] : `UVRB_ADDR_NONE;

    function hit;
        input [5:0] a;
        input [5:0] target;
        begin
            hit = (a == target) && (a[5:4] == `UVRB_ADDR_VENDOR_HI);
        end
    endfunction

    // set/clear/write merge shared by the two triple-address registers
    function [7:0] merge;
        input [7:0] cur;
        input [7:0] d;
        input [1:0] op;
        input [7:0] mask;
        begin
            case (op)
                2'h1: merge = (cur | d) & mask;
                2'h2: merge = cur & ~d & mask;
                default: merge = d & mask;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------

    // analog result and mode levels come from other domains
    // the converter code is taken only at completion, long after it has settled
    always @(posedge ref_clk) begin
        if (rst) begin
            adc_meta <= 3'h0;
            adc_sync <= 3'h0;
            uart_meta <= 1'b0;
            uart_sync <= 1'b0;
            txd_meta <= 1'b0;
            txd_sync <= 1'b0;
            ck_en_meta <= 1'b0;
            ck_en_sync <= 1'b0;
            ck_rd_meta <= 1'b0;
            ck_rd_sync <= 1'b0;
        end else begin
            adc_meta <= id_adc_code;
            adc_sync <= adc_meta;
            uart_meta <= uart_mode;
            uart_sync <= uart_meta;
            txd_meta <= serial_transmit_enable;
            txd_sync <= txd_meta;
            ck_en_meta <= carkit_irq_enable;
            ck_en_sync <= ck_en_meta;
            ck_rd_meta <= carkit_status_rd;
            ck_rd_sync <= ck_rd_meta;
        end
    end

    // ------------------------------------------------------------
    // register views
    // ------------------------------------------------------------

    assign idc_view = {1'b0, idc_ctrl[6], 1'b0, idc_ctrl[4], id_conv_complete, id_resistance_code};
    assign io_view = {io_reg, 1'b0};
    assign irq_en = idc_ctrl[`UVRB_IDC_IRQEN] | ck_en_sync;
    assign conv_done = idc_ctrl[`UVRB_IDC_TRIG] && (conv_cnt == CONV_CYCLES[CNT_W-1:0]);
    // three aliases of the conversion register, three of the io register
    assign idc_hit = hit(eff_addr, `UVRB_ADDR_IDC_WR) || hit(eff_addr, `UVRB_ADDR_IDC_SET)
                     || hit(eff_addr, `UVRB_ADDR_IDC_CLR);
    assign io_hit = hit(eff_addr, `UVRB_ADDR_IO_WR) || hit(eff_addr, `UVRB_ADDR_IO_SET)
                    || hit(eff_addr, `UVRB_ADDR_IO_CLR);
    // byte-wide reset image, only bits 7:1 are stored
    assign io_rst_val = `UVRB_RST_IO;

    // ------------------------------------------------------------
    // write, set and clear merge
    // ------------------------------------------------------------

    // conversion merge
    // whole bytes are merged; the mask passes reserved bit 5, which the register forces to zero
    always @* begin
        next_idc = idc_view;
        if (hit(eff_addr, `UVRB_ADDR_IDC_WR))
            next_idc = merge(idc_view, reg_wdata, 2'h0, `UVRB_MASK_IDC);
        else if (hit(eff_addr, `UVRB_ADDR_IDC_SET))
            next_idc = merge(idc_view, reg_wdata, 2'h1, `UVRB_MASK_IDC);
        else if (hit(eff_addr, `UVRB_ADDR_IDC_CLR))
            next_idc = merge(idc_view, reg_wdata, 2'h2, `UVRB_MASK_IDC);
    end

    always @* begin
        next_io = io_view;
        if (hit(eff_addr, `UVRB_ADDR_IO_WR))
            next_io = merge(io_view, reg_wdata, 2'h0, `UVRB_MASK_IO);
        else if (hit(eff_addr, `UVRB_ADDR_IO_SET))
            next_io = merge(io_view, reg_wdata, 2'h1, `UVRB_MASK_IO);
        else if (hit(eff_addr, `UVRB_ADDR_IO_CLR))
            next_io = merge(io_view, reg_wdata, 2'h2, `UVRB_MASK_IO);
    end

    // ------------------------------------------------------------
    // plain read/write registers and the io register store
    // ------------------------------------------------------------

    always @(posedge ref_clk) begin
        if (rst) begin
            amp_reg <= `UVRB_RST_TX_AMP;
            key_reg <= `UVRB_RST_HS_KEY;
        end else if (reg_wr_stb) begin
            if (hit(eff_addr, `UVRB_ADDR_TX_AMP))
                amp_reg <= reg_wdata & `UVRB_MASK_TX_AMP;
            if (hit(eff_addr, `UVRB_ADDR_HS_KEY))
                key_reg <= reg_wdata & `UVRB_MASK_HS_KEY;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            io_reg <= io_rst_val[`UVRB_IO_USB_MSB:`UVRB_IO_SWAP];
        end else if (reg_wr_stb && io_hit) begin
            io_reg <= next_io[`UVRB_IO_USB_MSB:`UVRB_IO_SWAP];
        end
    end

    // ------------------------------------------------------------
    // id resistance conversion
    // ------------------------------------------------------------

    // conversion write set clear
    // hardware completion wins over a simultaneous software write of the trigger
    // other bits of a write landing in the completion cycle still take effect
    always @(posedge ref_clk) begin
        if (rst) begin
            idc_ctrl <= 3'h0;
        end else begin
            if (reg_wr_stb && idc_hit)
                idc_ctrl <= next_idc[`UVRB_IDC_IRQEN:`UVRB_IDC_TRIG];
            idc_ctrl[`UVRB_IDC_RSVD] <= 1'b0;
            if (conv_done)
                idc_ctrl[`UVRB_IDC_TRIG] <= 1'b0;
        end
    end

    // conversion timer
    // restarts from zero whenever the trigger is low
    // a second trigger during a run does not restart the count
    always @(posedge ref_clk) begin
        if (rst) begin
            conv_cnt <= {CNT_W{1'b0}};
        end else if (!idc_ctrl[`UVRB_IDC_TRIG] || conv_done) begin
            conv_cnt <= {CNT_W{1'b0}};
        end else begin
            conv_cnt <= conv_cnt + 1'b1;
        end
    end

    // result capture, flag set, flag clear on read
    // set beats a same-cycle clear so a completion is never lost
    always @(posedge ref_clk) begin
        if (rst) begin
            id_resistance_code <= 3'h0;
            id_conv_complete <= 1'b0;
        end else if (conv_done) begin
            id_resistance_code <= adc_sync;
            id_conv_complete <= 1'b1;
        end else if (reg_rd_stb && (hit(eff_addr, `UVRB_ADDR_IDC_WR) || hit(eff_addr, `UVRB_ADDR_IDC_SET)
                     || hit(eff_addr, `UVRB_ADDR_IDC_CLR))) begin
            id_conv_complete <= 1'b0;
        end
    end

    // alternate interrupt
    // one pulse per rising completion; carkit status reads do not touch the flag
    // limitation: a completion in a synced carkit status read cycle loses its pulse
    always @(posedge ref_clk) begin
        if (rst)
            alt_irq <= 1'b0;
        else
            alt_irq <= conv_done && irq_en && !ck_rd_sync;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------

    // conversion read alias, io read alias
    // unmapped and out-of-range addresses read as zero
    always @* begin
        next_rdata = 8'h00;
        if (hit(eff_addr, `UVRB_ADDR_TX_AMP))
            next_rdata = amp_reg;
        else if (hit(eff_addr, `UVRB_ADDR_HS_KEY))
            next_rdata = key_reg;
        else if (hit(eff_addr, `UVRB_ADDR_IDC_WR) || hit(eff_addr, `UVRB_ADDR_IDC_SET)
                 || hit(eff_addr, `UVRB_ADDR_IDC_CLR))
            next_rdata = idc_view;
        else if (hit(eff_addr, `UVRB_ADDR_IO_WR) || hit(eff_addr, `UVRB_ADDR_IO_SET)
                 || hit(eff_addr, `UVRB_ADDR_IO_CLR))
            next_rdata = io_view;
    end

    // data lags the strobe by one cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_stb;
            if (reg_rd_stb)
                reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------

    // registered so every control output is glitch free
    always @(posedge ref_clk) begin
        if (rst) begin
            tx_amplitude <= 2'h0;
            headset_mode_on <= 1'b0;
            id_conv_run <= 1'b0;
            data_line_exchange <= 1'b0;
            ldo_level <= 2'h0;
            charger_pullup_plus <= 1'b0;
            charger_pullup_minus <= 1'b0;
        end else begin
            tx_amplitude <= amp_reg[`UVRB_TX_AMP_MSB:`UVRB_TX_AMP_LSB];
            headset_mode_on <= (key_reg[`UVRB_HS_KEY_MSB:0] == `UVRB_HS_KEY_ON);
            id_conv_run <= idc_ctrl[`UVRB_IDC_TRIG];
            data_line_exchange <= io_view[`UVRB_IO_SWAP];
            // uart level, usb level
            // in uart mode the usb level stands until transmit enable is seen
            if (uart_sync && txd_sync)
                ldo_level <= io_view[`UVRB_IO_SER_MSB:`UVRB_IO_SER_LSB];
            else if (!uart_sync)
                ldo_level <= io_view[`UVRB_IO_USB_MSB:`UVRB_IO_USB_LSB];
            charger_pullup_plus <= io_view[`UVRB_IO_PU_PLUS] | uart_sync;
            charger_pullup_minus <= io_view[`UVRB_IO_PU_MINUS] | uart_sync;
        end
    end

endmodule

// ===== verification/tb_top.sv
// self-checking bench for the vendor register bank
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic carkit_irq_enable = 1'b0;
    logic uart_mode = 1'b0;
    logic txd_en = 1'b0;
    logic ck_rd = 1'b0;
    logic [2:0] adc = 3'h0;
    logic [7:0] got;
    logic [7:0] ra [6] = '{8'h31, 8'h33, 8'h36, 8'h39, 8'h3B, 8'h30};
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00};
    int fails = 0;
    int checks = 0;
    int irqs = 0;
    int i;
    wire wr_stb, rd_stb, ext, rd_valid, key_on, run, done, irq, swap, pu_p, pu_m;
    wire [7:0] addr, wdata, rdata;
    wire [1:0] amp, ldo;
    wire [2:0] code;
    uvrb_register_bank #(.CONV_CYCLES(20), .CNT_W(15)) uut (.ref_clk(ref_clk), .rst(rst),
        .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .reg_ext(ext), .reg_addr(addr), .reg_wdata(wdata),
        .carkit_irq_enable(carkit_irq_enable), .carkit_status_rd(ck_rd), .uart_mode(uart_mode),
        .serial_transmit_enable(txd_en), .id_adc_code(adc), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
        .tx_amplitude(amp), .headset_mode_on(key_on), .id_conv_run(run), .id_resistance_code(code),
        .id_conv_complete(done), .alt_irq(irq), .data_line_exchange(swap), .ldo_level(ldo),
        .charger_pullup_plus(pu_p), .charger_pullup_minus(pu_m));
    uvrb_link_model link (.ref_clk(ref_clk), .reg_rdata(rdata), .reg_rd_valid(rd_valid), .reg_wr_stb(wr_stb),
        .reg_rd_stb(rd_stb), .reg_ext(ext), .reg_addr(addr), .reg_wdata(wdata));
    // clock and interrupt pulse counter
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irq === 1'b1) irqs++;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [7:0] exp);
        link.rd(a, 1'b0, got);
        chk($sformatf("reg %h", a), exp, got);
    endtask
    // outputs follow two cycles after the write
    task w(input logic [7:0] a, input logic [7:0] d);
        link.wr(a, d);
        repeat (2) @(negedge ref_clk);
    endtask
    task conv_wait;
        for (i = 0; i < 100 && done !== 1'b1; i++) @(negedge ref_clk);
        repeat (2) @(negedge ref_clk);
    endtask
    task complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog well past the expected few hundred cycles
    initial begin
        #300000;
        fails++;
        complete_run;
    end
    // main sequence
    initial begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        for (int k = 0; k < 6; k++) rchk(ra[k], rv[k]);
        link.rd(8'h39, 1'b1, got);
        chk("extended read", 8'h04, got);
        link.rd(8'h79, 1'b1, got);
        chk("extended out of range", 8'h00, got);
        for (int k = 0; k < 4; k++) begin
            w(8'h31, {1'b1, k[1:0], 5'h1F});
            rchk(8'h31, {1'b0, k[1:0], 5'h00});
            chk("tx_amplitude", {6'h00, k[1:0]}, {6'h00, amp});
        end
        w(8'h33, 8'hFA);
        rchk(8'h33, 8'h0A);
        chk("headset_mode_on", 8'h01, {7'h00, key_on});
        w(8'h33, 8'h0B);
        chk("headset_mode_on", 8'h00, {7'h00, key_on});
        w(8'h30, 8'hFF);
        rchk(8'h30, 8'h00);
        w(8'h39, 8'h01);
        w(8'h3A, 8'h72);
        rchk(8'h3B, 8'h72);
        chk("swap pullups ldo", 8'hE1, {swap, pu_p, pu_m, 3'h0, ldo});
        w(8'h3B, 8'h32);
        rchk(8'h3A, 8'h40);
        chk("swap pullups ldo", 8'h01, {swap, pu_p, pu_m, 3'h0, ldo});
        w(8'h39, 8'h08);
        uart_mode = 1'b1;
        txd_en = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk("uart pullups ldo", 8'h62, {1'b0, pu_p, pu_m, 3'h0, ldo});
        uart_mode = 1'b0;
        txd_en = 1'b0;
        carkit_irq_enable = 1'b1;
        adc = 3'h5;
        repeat (6) @(negedge ref_clk);
        chk("usb ldo", 8'h00, {6'h00, ldo});
        w(8'h37, 8'h10);
        chk("id_conv_run", 8'h01, {7'h00, run});
        conv_wait;
        ck_rd = 1'b1;
        repeat (3) @(negedge ref_clk);
        ck_rd = 1'b0;
        chk("code done irqs", 8'hB1, {code, done, 2'h0, irqs[1:0]});
        rchk(8'h36, 8'h0D);
        rchk(8'h36, 8'h05);
        w(8'h37, 8'h40);
        rchk(8'h38, 8'h45);
        w(8'h38, 8'h40);
        rchk(8'h37, 8'h05);
        carkit_irq_enable = 1'b0;
        adc = 3'h7;
        repeat (4) @(negedge ref_clk);
        w(8'h36, 8'h70);
        conv_wait;
        chk("code done irqs", 8'hF2, {code, done, 2'h0, irqs[1:0]});
        rchk(8'h36, 8'h4F);
        w(8'h36, 8'h10);
        conv_wait;
        chk("irqs disabled", 8'h02, irqs[7:0]);
        complete_run;
    end
endmodule

// ===== verification/uvrb_link_model.sv
// link controller model issuing immediate register writes and immediate or extended reads
`timescale 1ns/1ps
module uvrb_link_model (
    input wire ref_clk,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid,
    output reg reg_wr_stb,
    output reg reg_rd_stb,
    output reg reg_ext,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_ext = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one-cycle write strobe, data inverted once released
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = (a >= 8'h36 && a <= 8'h38) ? (d & 8'hDF) : d;
        reg_wr_stb = 1'b1;
        @(negedge ref_clk);
        reg_wr_stb = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    // read, address held until the answer shows
    task rd(input logic [7:0] a, input logic ext, output logic [7:0] d);
        int n;
        @(negedge ref_clk);
        reg_addr = a;
        reg_ext = ext;
        reg_rd_stb = 1'b1;
        @(negedge ref_clk);
        reg_rd_stb = 1'b0;
        for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++) @(negedge ref_clk);
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hXX;
        reg_ext = 1'b0;
    endtask
endmodule

// ===== verification/uvrb_props.sv
// port assertions for the vendor register bank
`timescale 1ns/1ps
module uvrb_props #(
    parameter CONV_CYCLES = 20
) (
    input wire ref_clk,
    input wire rst,
    input wire reg_wr_stb,
    input wire reg_rd_stb,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire carkit_irq_enable,
    input wire uart_mode,
    input wire reg_rd_valid,
    input wire [1:0] tx_amplitude,
    input wire headset_mode_on,
    input wire id_conv_run,
    input wire id_conv_complete,
    input wire alt_irq,
    input wire data_line_exchange,
    input wire charger_pullup_plus,
    input wire charger_pullup_minus
);
    localparam int C_LO = CONV_CYCLES - 1;
    localparam int C_HI = CONV_CYCLES + 2;
    // write decodes, low six address bits only
    wire wr_amp = reg_wr_stb && reg_addr[5:0] == 6'h31;
    wire wr_key = reg_wr_stb && reg_addr[5:0] == 6'h33;
    wire wr_io = reg_wr_stb && reg_addr[5:0] == 6'h39;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rd; reg_rd_stb |=> reg_rd_valid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_no_rd; reg_rd_valid |-> $past(reg_rd_stb); endproperty
    a_no_rd: assert property (p_no_rd) else $error("valid without read");
    property p_amp; wr_amp |-> ##2 tx_amplitude == $past(reg_wdata[6:5], 2); endproperty
    a_amp: assert property (p_amp) else $error("amplitude not applied");
    property p_key_on; wr_key && reg_wdata[3:0] == 4'hA |-> ##2 headset_mode_on; endproperty
    a_key_on: assert property (p_key_on) else $error("headset mode not on");
    property p_key_off; wr_key && reg_wdata[3:0] != 4'hA |-> ##2 !headset_mode_on; endproperty
    a_key_off: assert property (p_key_off) else $error("headset mode on");
    property p_swap; wr_io |-> ##2 data_line_exchange == $past(reg_wdata[1], 2); endproperty
    a_swap: assert property (p_swap) else $error("swap not applied");
    property p_conv; $rose(id_conv_run) |-> ##[C_LO:C_HI] $rose(id_conv_complete); endproperty
    a_conv: assert property (p_conv) else $error("conversion time wrong");
    property p_run_end; $fell(id_conv_run) |-> $past(id_conv_complete); endproperty
    a_run_end: assert property (p_run_end) else $error("trigger cleared early");
    property p_irq; $rose(id_conv_complete) && carkit_irq_enable |-> alt_irq; endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");
    property p_irq_src; alt_irq |-> id_conv_complete && !$past(id_conv_complete); endproperty
    a_irq_src: assert property (p_irq_src) else $error("interrupt without completion");
    property p_uart_pu; uart_mode[*5] |-> charger_pullup_plus && charger_pullup_minus; endproperty
    a_uart_pu: assert property (p_uart_pu) else $error("uart pull-ups off");
    c_irq: cover property ($rose(alt_irq));
    c_key: cover property ($rose(headset_mode_on));
    c_uart: cover property (uart_mode && charger_pullup_plus);
endmodule

bind uvrb_register_bank uvrb_props #(.CONV_CYCLES(CONV_CYCLES)) u_props (
    .ref_clk(ref_clk), .rst(rst), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .carkit_irq_enable(carkit_irq_enable), .uart_mode(uart_mode),
    .reg_rd_valid(reg_rd_valid), .tx_amplitude(tx_amplitude), .headset_mode_on(headset_mode_on),
    .id_conv_run(id_conv_run), .id_conv_complete(id_conv_complete), .alt_irq(alt_irq),
    .data_line_exchange(data_line_exchange), .charger_pullup_plus(charger_pullup_plus),
    .charger_pullup_minus(charger_pullup_minus));
